// file: verilog/ism_pkg.sv
// constants and types for the two-wire master start and clock arbitration block
package ism_pkg;
    localparam int unsigned RELOAD_W   = 8;
    localparam int unsigned REQ_BITS   = 5;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned START_BIT  = 0;
    localparam logic [7:0]  RELOAD_RST = 8'h00;
    localparam logic [7:0]  TXBUF_RST  = 8'h00;
    localparam logic [4:0]  REQ_RST    = 5'h00;

    typedef enum logic [2:0] {
        ISM_IDLE,
        ISM_ST_WAIT1,
        ISM_ST_WAIT2,
        ISM_SEQ,
        ISM_SCL_REL
    } ism_state_t;
endpackage : ism_pkg

// file: verilog/ism_sync.sv
// three-stage input synchroniser with agreement filter
module ism_sync (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // pin in, filtered level out
    input  wire logic pin_i,
    output logic      lvl_o
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            s3_ff <= 1'b1;
        end else begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // idle bus reads high
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            lvl_o <= 1'b1;
        end else if (s2_ff == s3_ff) begin
            lvl_o <= s3_ff;
        end
    end
endmodule : ism_sync

// file: verilog/ism_top.sv
// start generation, clock arbitration and write collision guard
module ism_top (
    // clock and reset
    input  wire logic                            mclk_i,
    input  wire logic                            rst_i,
    // configuration
    input  wire logic [ism_pkg::RELOAD_W-1:0]    brg_reload_value_i,
    // control register 2 write port
    input  wire logic                            ctrl2_wr_i,
    input  wire logic [ism_pkg::REQ_BITS-1:0]    ctrl2_wdata_i,
    // transmit buffer write port
    input  wire logic                            txbuf_wr_i,
    input  wire logic [ism_pkg::DATA_W-1:0]      txbuf_wdata_i,
    // flag clears
    input  wire logic                            write_collision_flag_clr_i,
    input  wire logic                            bcol_clr_i,
    input  wire logic                            start_det_clr_i,
    // rest of master: sequence busy and clock release request
    input  wire logic                            seq_busy_i,
    input  wire logic                            scl_release_i,
    // bus pins
    input  wire logic                            scl_i,
    input  wire logic                            sda_i,
    output logic                                 scl_oe_n_o,
    output logic                                 sda_oe_n_o,
    // status
    output logic [ism_pkg::REQ_BITS-1:0]         serial_control_2_o,
    output logic [ism_pkg::DATA_W-1:0]           serial_tx_buffer_o,
    output logic                                 write_collision_flag_o,
    output logic                                 bus_collision_flag_o,
    output logic                                 start_detected_o,
    output logic                                 brg_timeout_o,
    output logic                                 idle_o
);
    logic                          scl_lvl;
    logic                          sda_lvl;
    logic [ism_pkg::RELOAD_W-1:0]  brg_cnt_ff;
    logic                          brg_run_ff;
    logic                          brg_tick;
    ism_pkg::ism_state_t           state_ff;
    logic                          start_go;
    logic                          abort;

    ism_sync u_scl_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .pin_i  (scl_i),
        .lvl_o  (scl_lvl)
    );

    ism_sync u_sda_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .pin_i  (sda_i),
        .lvl_o  (sda_lvl)
    );

    assign brg_tick = brg_run_ff && (brg_cnt_ff == '0);
    assign start_go = (state_ff == ism_pkg::ISM_IDLE)
                      && serial_control_2_o[ism_pkg::START_BIT];
    // collision: low lines at begin, or clock low before data dropped
    assign abort = (start_go && !(scl_lvl && sda_lvl))
                   || ((state_ff == ism_pkg::ISM_ST_WAIT1) && !scl_lvl);

    // sequence state
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= ism_pkg::ISM_IDLE;
        end else begin
            unique case (state_ff)
                ism_pkg::ISM_IDLE: begin
                    if (start_go && !abort) begin
                        state_ff <= ism_pkg::ISM_ST_WAIT1;
                    end else if (scl_release_i) begin
                        state_ff <= ism_pkg::ISM_SCL_REL;
                    end else if (seq_busy_i) begin
                        state_ff <= ism_pkg::ISM_SEQ;
                    end
                end
                ism_pkg::ISM_ST_WAIT1: begin
                    if (abort) begin
                        state_ff <= ism_pkg::ISM_IDLE;
                    end else if (brg_tick && sda_lvl) begin
                        state_ff <= ism_pkg::ISM_ST_WAIT2;
                    end
                end
                ism_pkg::ISM_ST_WAIT2: begin
                    if (brg_tick) begin
                        state_ff <= ism_pkg::ISM_IDLE;
                    end
                end
                ism_pkg::ISM_SEQ: begin
                    if (scl_release_i) begin
                        state_ff <= ism_pkg::ISM_SCL_REL;
                    end else if (!seq_busy_i) begin
                        state_ff <= ism_pkg::ISM_IDLE;
                    end
                end
                ism_pkg::ISM_SCL_REL: begin
                    if (!scl_release_i) begin
                        state_ff <= seq_busy_i ? ism_pkg::ISM_SEQ : ism_pkg::ISM_IDLE;
                    end
                end
            endcase
        end
    end

    // baud rate generator
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            brg_cnt_ff <= ism_pkg::RELOAD_RST;
            brg_run_ff <= 1'b0;
        end else if (start_go && !abort) begin
            brg_cnt_ff <= brg_reload_value_i;
            brg_run_ff <= 1'b1;
        end else if (state_ff == ism_pkg::ISM_SCL_REL) begin
            if (!scl_lvl) begin
                brg_run_ff <= 1'b0;
                brg_cnt_ff <= brg_reload_value_i;
            end else if (!brg_run_ff) begin
                brg_run_ff <= 1'b1;
                brg_cnt_ff <= brg_reload_value_i;
            end else if (brg_tick) begin
                brg_cnt_ff <= brg_reload_value_i;
            end else begin
                brg_cnt_ff <= brg_cnt_ff - 8'h01;
            end
        end else if (state_ff == ism_pkg::ISM_ST_WAIT1 && brg_tick && !abort) begin
            brg_cnt_ff <= brg_reload_value_i;
        end else if (state_ff == ism_pkg::ISM_ST_WAIT2 && brg_tick) begin
            brg_run_ff <= 1'b0;
        end else if (abort || state_ff == ism_pkg::ISM_IDLE) begin
            brg_run_ff <= 1'b0;
        end else if (brg_run_ff) begin
            brg_cnt_ff <= brg_tick ? brg_reload_value_i : brg_cnt_ff - 8'h01;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            brg_timeout_o <= 1'b0;
        end else begin
            brg_timeout_o <= brg_tick;
        end
    end

    // data line: held low from start drop until rest of master takes over
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_oe_n_o <= 1'b1;
        end else if (abort) begin
            sda_oe_n_o <= 1'b1;
        end else if (state_ff == ism_pkg::ISM_ST_WAIT1 && brg_tick && sda_lvl) begin
            sda_oe_n_o <= 1'b0;
        end else if (state_ff == ism_pkg::ISM_SEQ || start_go) begin
            sda_oe_n_o <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_oe_n_o <= 1'b1;
        end else begin
            scl_oe_n_o <= 1'b1;
        end
    end

    // control register 2 request bits
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_control_2_o <= ism_pkg::REQ_RST;
        end else if (state_ff == ism_pkg::ISM_ST_WAIT2 && brg_tick) begin
            serial_control_2_o[ism_pkg::START_BIT] <= 1'b0;
        end else if (abort) begin
            serial_control_2_o[ism_pkg::START_BIT] <= 1'b0;
        end else if (ctrl2_wr_i && !serial_control_2_o[ism_pkg::START_BIT]) begin
            serial_control_2_o <= ctrl2_wdata_i;
        end
    end

    // start detected
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            start_detected_o <= 1'b0;
        end else if (state_ff == ism_pkg::ISM_ST_WAIT1 && brg_tick && sda_lvl && !abort) begin
            start_detected_o <= 1'b1;
        end else if (start_det_clr_i) begin
            start_detected_o <= 1'b0;
        end
    end

    // transmit buffer and write collision
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_tx_buffer_o <= ism_pkg::TXBUF_RST;
        end else if (txbuf_wr_i && state_ff == ism_pkg::ISM_IDLE && !start_go) begin
            serial_tx_buffer_o <= txbuf_wdata_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            write_collision_flag_o <= 1'b0;
        end else if (txbuf_wr_i && (state_ff != ism_pkg::ISM_IDLE || start_go)) begin
            write_collision_flag_o <= 1'b1;
        end else if (write_collision_flag_clr_i) begin
            write_collision_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_collision_flag_o <= 1'b0;
        end else if (abort) begin
            bus_collision_flag_o <= 1'b1;
        end else if (bcol_clr_i) begin
            bus_collision_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            idle_o <= 1'b1;
        end else begin
            idle_o <= (state_ff == ism_pkg::ISM_IDLE) && !start_go;
        end
    end
endmodule : ism_top

// file: dv/ism_bus_model.sv
// two-wire bus partner: pull-ups, clock stretch, second data driver
module ism_bus_model (
    // enables from the block, active low
    input  wire logic scl_oe_n_i,
    input  wire logic sda_oe_n_i,
    // far-side devices pulling the lines low
    input  wire logic hold_scl_i,
    input  wire logic hold_sda_i,
    // resolved line levels
    output logic      scl_o,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // wired-and lines, pulled high when nobody drives
    assign scl_o = scl_oe_n_i & ~hold_scl_i;
    assign sda_o = sda_oe_n_i & ~hold_sda_i;
endmodule : ism_bus_model

// file: dv/ism_properties.sv
// assertions on start generation and clock arbitration
module ism_properties (
    // clock and reset
    input wire logic       mclk_i,
    input wire logic       rst_i,
    // inputs of the block
    input wire logic       ctrl2_wr_i,
    input wire logic       txbuf_wr_i,
    input wire logic       write_collision_flag_clr_i,
    input wire logic       bcol_clr_i,
    input wire logic       scl_release_i,
    input wire logic       scl_i,
    // outputs of the block
    input wire logic       sda_oe_n_o,
    input wire logic [4:0] serial_control_2_o,
    input wire logic [7:0] serial_tx_buffer_o,
    input wire logic       write_collision_flag_o,
    input wire logic       bus_collision_flag_o,
    input wire logic       start_detected_o,
    input wire logic       brg_timeout_o,
    input wire logic       idle_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    // second half of a start ends with the request bit dropping
    sequence start_done;
        ##[1:300] $fell(serial_control_2_o[0]);
    endsequence
    a_write_collision_flag_sticky: assert property (
        write_collision_flag_o && !write_collision_flag_clr_i |=> write_collision_flag_o) else $error("wc lost");
    a_bcol_sticky: assert property (
        bus_collision_flag_o && !bcol_clr_i |=> bus_collision_flag_o) else $error("bc lost");
    a_buf_guard: assert property (
        txbuf_wr_i && serial_control_2_o[0] |=>
        write_collision_flag_o && $stable(serial_tx_buffer_o)) else $error("buffer written");
    a_req_locked: assert property (
        ctrl2_wr_i && serial_control_2_o[0] |=> $stable(serial_control_2_o[4:1]))
        else $error("request bits written");
    a_start_flag: assert property (
        $fell(sda_oe_n_o) |-> ##[0:1] start_detected_o) else $error("start flag missing");
    a_start_end: assert property (
        $fell(sda_oe_n_o) |-> !sda_oe_n_o throughout start_done) else $error("start end");
    a_abort_idle: assert property (
        $rose(bus_collision_flag_o) |-> ##[0:2]
        (idle_o && sda_oe_n_o && !serial_control_2_o[0])) else $error("abort not idle");
    a_stretch_hold: assert property (
        (scl_release_i && !scl_i && !serial_control_2_o[0])[*8] |-> !brg_timeout_o)
        else $error("count ran while stretched");
endmodule : ism_properties

// file: dv/ism_top_tb.sv
// self-checking bench for start generation and clock arbitration
module ism_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk_i = 1'b0, rst_i = 1'b1, ctrl2_wr_i = 1'b0, txbuf_wr_i = 1'b0;
    logic       write_collision_flag_clr_i = 1'b0, bcol_clr_i = 1'b0, start_det_clr_i = 1'b0;
    logic       seq_busy_i = 1'b0, scl_release_i = 1'b0, hold_scl = 1'b0, hold_sda = 1'b0;
    logic       scl_i, sda_i, scl_oe_n_o, sda_oe_n_o, write_collision_flag_o;
    logic       bus_collision_flag_o, start_detected_o, brg_timeout_o, idle_o;
    logic [4:0] ctrl2_wdata_i = 5'h00, serial_control_2_o;
    logic [7:0] brg_reload_value_i = 8'h08, txbuf_wdata_i = 8'h00, serial_tx_buffer_o, r, b;
    int         failures = 0, checks = 0, n, seed = 19256;

    ism_top ism_top_i (.*);
    ism_bus_model ism_bus_model_i (.scl_oe_n_i(scl_oe_n_o), .sda_oe_n_i(sda_oe_n_o),
        .hold_scl_i(hold_scl), .hold_sda_i(hold_sda), .scl_o(scl_i), .sda_o(sda_i));

    initial begin
        forever #4 mclk_i = ~mclk_i;
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task tmo;
        if (n >= 600) begin
            failures++;
            results();
        end
    endtask : tmo

    // k: 0 control write, 1 buffer write, 2 flag clears
    task pulse(input int k, input logic [7:0] d);
        @(posedge mclk_i);
        ctrl2_wdata_i <= d[4:0];
        txbuf_wdata_i <= d;
        ctrl2_wr_i <= (k == 0);
        txbuf_wr_i <= (k == 1);
        write_collision_flag_clr_i <= (k == 2);
        bcol_clr_i <= (k == 2);
        start_det_clr_i <= (k == 2);
        @(posedge mclk_i);
        {ctrl2_wr_i, txbuf_wr_i, write_collision_flag_clr_i, bcol_clr_i, start_det_clr_i} <= 5'h00;
        @(negedge mclk_i);
    endtask : pulse

    initial begin
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        b = 8'($random(seed));
        pulse(1, b);
        chk(serial_tx_buffer_o, b);
        repeat (3) begin
            r = {2'h0, 6'($random(seed))} + 8'h08;
            @(posedge mclk_i);
            brg_reload_value_i <= r;
            pulse(2, b);
            chk(write_collision_flag_o, 8'h00);
            pulse(0, 8'h01);
            pulse(1, ~b);
            chk(write_collision_flag_o, 8'h01);
            chk(serial_tx_buffer_o, b);
            pulse(0, 8'h1e);
            chk(serial_control_2_o, 8'h01);
            for (n = 0; n < 600 && sda_oe_n_o; n++) @(negedge mclk_i);
            tmo();
            chk(start_detected_o, 8'h01);
            chk(scl_oe_n_o, 8'h01);
            for (n = 0; n < 600 && serial_control_2_o[0]; n++) @(negedge mclk_i);
            tmo();
            chk(8'(n), r + 8'h01);
            chk(sda_oe_n_o, 8'h00);
            @(negedge mclk_i);
            chk({idle_o, write_collision_flag_o}, 8'h03);
            // generator must stay suspended once start is complete
            n = 0;
            repeat (r + 2) begin
                @(negedge mclk_i);
                n += brg_timeout_o;
            end
            chk(8'(n), 8'h00);
            pulse(2, b);
            chk(start_detected_o, 8'h00);
            @(posedge mclk_i);
            seq_busy_i <= 1'b1;
            pulse(1, ~b);
            chk(write_collision_flag_o, 8'h01);
            chk(serial_tx_buffer_o, b);
            @(posedge mclk_i);
            seq_busy_i <= 1'b0;
        end
        $display("start test done");
        // scl low at request, scl low mid-start, sda low at request
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk_i);
            hold_scl <= (k == 0);
            hold_sda <= (k == 2);
            repeat (6) @(posedge mclk_i);
            pulse(0, 8'h01);
            @(posedge mclk_i);
            hold_scl <= 1'b1;
            for (n = 0; n < 600 && !bus_collision_flag_o; n++) @(negedge mclk_i);
            tmo();
            repeat (3) @(negedge mclk_i);
            chk({sda_oe_n_o, idle_o, serial_control_2_o[0], bus_collision_flag_o}, 8'h0d);
            @(posedge mclk_i);
            hold_scl <= 1'b0;
            hold_sda <= 1'b0;
            pulse(2, b);
            chk(bus_collision_flag_o, 8'h00);
        end
        $display("collision test done");
        repeat (3) begin
            @(posedge mclk_i);
            hold_scl <= 1'b1;
            repeat (6) @(posedge mclk_i);
            scl_release_i <= 1'b1;
            n = 0;
            repeat (r + 8'($random(seed) & 8'h1f) + 8) begin
                @(negedge mclk_i);
                n += brg_timeout_o;
            end
            chk(8'(n), 8'h00);
            @(posedge mclk_i);
            hold_scl <= 1'b0;
            for (n = 0; n < 600 && !brg_timeout_o; n++) @(negedge mclk_i);
            tmo();
            chk(8'(n >= r + 1 && n <= r + 8), 8'h01);
            @(posedge mclk_i);
            scl_release_i <= 1'b0;
        end
        $display("arbitration test done");
        results();
    end
endmodule : ism_top_tb

bind ism_top ism_properties ism_properties_i (.*);
